/* core/hwopt_pkg.sv */
// option register bank: shared constants and carrier types
// assumes a 32-bit ahb-lite bus with one slave on it
package hwopt_pkg;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [15:0] HWOPT_OFS_A = 16'h001f; // register index a
	localparam logic [15:0] HWOPT_OFS_B = 16'h0020; // register index b
	localparam logic [17:0] HWOPT_ADDR_A = {HWOPT_OFS_A, 2'b00};
	localparam logic [17:0] HWOPT_ADDR_B = {HWOPT_OFS_B, 2'b00};

	// ************************************************************
	// field positions, register a
	// ************************************************************
	localparam int HWOPT_A_MON_STOP = 7;
	localparam int HWOPT_A_PGM_SEC  = 6;
	localparam int HWOPT_A_MON_RST  = 5;
	localparam int HWOPT_A_MON_PWR  = 4;
	localparam int HWOPT_A_SHORT    = 3;
	localparam int HWOPT_A_WD_RATE  = 2;
	localparam int HWOPT_A_STOP_EN  = 1;
	localparam int HWOPT_A_WD_DIS   = 0;

	// ************************************************************
	// field positions, register b
	// ************************************************************
	localparam int HWOPT_B_EE_CLK   = 7;
	localparam int HWOPT_B_EE_MON   = 6;
	localparam int HWOPT_B_VARIANT  = 5;

	// ************************************************************
	// timing constants in crystal-clock cycles
	// ************************************************************
	localparam logic [12:0] HWOPT_RECOV_SHORT = 13'h0020; // 32
	localparam logic [12:0] HWOPT_RECOV_LONG  = 13'h1000; // 4096
	localparam logic [17:0] HWOPT_WD_SHORT    = 18'h01ff0; // 2^13 - 2^4
	localparam logic [17:0] HWOPT_WD_LONG     = 18'h3fff0; // 2^18 - 2^4

	// ************************************************************
	// reset value of the bus slave state
	// ************************************************************
	localparam logic [31:0] HWOPT_RDATA_RST = 32'h0000_0000;

	// decoded effects of the option bits
	typedef struct packed {
		logic        mon_power_en;
		logic        mon_reset_en;
		logic        mon_in_stop;
		logic        pgm_secure;
		logic        stop_legal;
		logic        wd_enable;
		logic [17:0] wd_timeout;
		logic [12:0] stop_recovery;
		logic        ee_clk_bus;
		logic        ee_mon_protect;
	} hwopt_ctrl_t;

	// ahb-lite request as sampled in the address phase
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [17:0] addr;
	} hwopt_req_t;

endpackage : hwopt_pkg

/* core/hwopt_decode.sv */
// option register bank: turns raw option bytes into control levels
// assumes option bytes are constant for the life of the device
`timescale 1ns/1ps
`default_nettype none
module hwopt_decode (
	input  wire logic [7:0]             opt_a,
	input  wire logic [7:0]             opt_b,
	output hwopt_pkg::hwopt_ctrl_t      ctrl
);

	// ************************************************************
	// option bit effects
	// ************************************************************
	always_comb begin
		ctrl.mon_power_en   = opt_a[hwopt_pkg::HWOPT_A_MON_PWR];
		ctrl.mon_reset_en   = opt_a[hwopt_pkg::HWOPT_A_MON_PWR]
			& opt_a[hwopt_pkg::HWOPT_A_MON_RST];
		ctrl.mon_in_stop    = opt_a[hwopt_pkg::HWOPT_A_MON_PWR]
			& opt_a[hwopt_pkg::HWOPT_A_MON_STOP];
		ctrl.pgm_secure     = opt_a[hwopt_pkg::HWOPT_A_PGM_SEC];
		ctrl.stop_legal     = opt_a[hwopt_pkg::HWOPT_A_STOP_EN];
		ctrl.wd_enable      = ~opt_a[hwopt_pkg::HWOPT_A_WD_DIS];
		ctrl.wd_timeout     = opt_a[hwopt_pkg::HWOPT_A_WD_RATE]
			? hwopt_pkg::HWOPT_WD_SHORT : hwopt_pkg::HWOPT_WD_LONG;
		ctrl.stop_recovery  = opt_a[hwopt_pkg::HWOPT_A_SHORT]
			? hwopt_pkg::HWOPT_RECOV_SHORT : hwopt_pkg::HWOPT_RECOV_LONG;
		ctrl.ee_clk_bus     = opt_b[hwopt_pkg::HWOPT_B_EE_CLK];
		ctrl.ee_mon_protect = opt_b[hwopt_pkg::HWOPT_B_EE_MON];
	end

endmodule : hwopt_decode
`default_nettype wire

/* core/hwopt_gate.sv */
// option register bank: applies option levels to live requests
// assumes request inputs are synchronous single-cycle levels
`timescale 1ns/1ps
`default_nettype none
module hwopt_gate (
	input  wire hwopt_pkg::hwopt_ctrl_t ctrl,
	input  wire logic                   stop_req,
	input  wire logic                   pgm_read_req,
	input  wire logic                   ee_read_req,
	input  wire logic                   monitor_mode,
	input  wire logic                   ee_code_ok,
	input  wire logic                   mon_detect,
	input  wire logic                   in_stop,
	output logic                        stop_ok,
	output logic                        stop_illegal,
	output logic                        pgm_read_ok,
	output logic                        ee_read_ok,
	output logic                        mon_active,
	output logic                        mon_reset
);

	// ************************************************************
	// instruction and access gating
	// ************************************************************
	always_comb begin
		stop_ok      = stop_req & ctrl.stop_legal;
		stop_illegal = stop_req & ~ctrl.stop_legal;
		pgm_read_ok  = pgm_read_req & ~(ctrl.pgm_secure & monitor_mode);
		ee_read_ok   = ee_read_req
			& ~(ctrl.ee_mon_protect & monitor_mode & ~ee_code_ok);
		mon_active   = ctrl.mon_power_en & (~in_stop | ctrl.mon_in_stop);
		mon_reset    = mon_active & ctrl.mon_reset_en & mon_detect;
	end

endmodule : hwopt_gate
`default_nettype wire

/* core/hwopt_top.sv */
// option register bank: two fixed option registers on ahb-lite,
// plus the control levels those bits drive into the rest of the chip
// assumes hclk at 200 MHz, one master, single word transfers
`timescale 1ns/1ps
`default_nettype none
module hwopt_top #(
	parameter logic [7:0] OPT_A   = 8'h13, // build-time option byte a
	parameter logic [1:0] OPT_B   = 2'h0,  // user bits 7:6 of byte b
	parameter logic       VARIANT = 1'b1   // arbitrary variant value
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [2:0]  hburst,
	input  wire logic [3:0]  hprot,
	input  wire logic        hmastlock,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        stop_req,
	input  wire logic        pgm_read_req,
	input  wire logic        ee_read_req,
	input  wire logic        monitor_mode,
	input  wire logic        ee_code_ok,
	input  wire logic        mon_detect,
	input  wire logic        in_stop,
	output logic             stop_ok,
	output logic             stop_illegal,
	output logic             pgm_read_ok,
	output logic             ee_read_ok,
	output logic             mon_active,
	output logic             mon_reset,
	output logic             wd_enable,
	output logic      [17:0] wd_timeout,
	output logic      [12:0] stop_recovery,
	output logic             ee_clk_bus
);

	// ************************************************************
	// fixed option bytes
	// ************************************************************
	logic [7:0] opt_a;
	logic [7:0] opt_b;
	hwopt_pkg::hwopt_ctrl_t ctrl;

	// constant wiring, no storage, so reset cannot alter it
	assign opt_a = OPT_A;
	assign opt_b = {OPT_B, VARIANT, 5'h00};

	// ************************************************************
	// option decode and request gating
	// ************************************************************
	logic g_stop_ok;
	logic g_stop_illegal;
	logic g_pgm_ok;
	logic g_ee_ok;
	logic g_mon_active;
	logic g_mon_reset;

	hwopt_decode u_decode (
		.opt_a (opt_a),
		.opt_b (opt_b),
		.ctrl  (ctrl)
	);

	hwopt_gate u_gate (
		.ctrl         (ctrl),
		.stop_req     (stop_req),
		.pgm_read_req (pgm_read_req),
		.ee_read_req  (ee_read_req),
		.monitor_mode (monitor_mode),
		.ee_code_ok   (ee_code_ok),
		.mon_detect   (mon_detect),
		.in_stop      (in_stop),
		.stop_ok      (g_stop_ok),
		.stop_illegal (g_stop_illegal),
		.pgm_read_ok  (g_pgm_ok),
		.ee_read_ok   (g_ee_ok),
		.mon_active   (g_mon_active),
		.mon_reset    (g_mon_reset)
	);

	// ************************************************************
	// registered control outputs
	// ************************************************************
	// gated requests, one cycle behind their inputs
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			stop_ok      <= 1'b0;
			stop_illegal <= 1'b0;
			pgm_read_ok  <= 1'b0;
			ee_read_ok   <= 1'b0;
			mon_active   <= 1'b0;
			mon_reset    <= 1'b0;
		end else begin
			stop_ok      <= g_stop_ok;
			stop_illegal <= g_stop_illegal;
			pgm_read_ok  <= g_pgm_ok;
			ee_read_ok   <= g_ee_ok;
			mon_active   <= g_mon_active;
			mon_reset    <= g_mon_reset;
		end
	end

	// static levels from the option bytes
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wd_enable     <= 1'b0;
			wd_timeout    <= hwopt_pkg::HWOPT_WD_LONG;
			stop_recovery <= hwopt_pkg::HWOPT_RECOV_LONG;
			ee_clk_bus    <= 1'b0;
		end else begin
			wd_enable     <= ctrl.wd_enable;
			wd_timeout    <= ctrl.wd_timeout;
			stop_recovery <= ctrl.stop_recovery;
			ee_clk_bus    <= ctrl.ee_clk_bus;
		end
	end

	// ************************************************************
	// ahb-lite slave
	// ************************************************************
	hwopt_pkg::hwopt_req_t req;

	// valid address phase when selected with a nonseq or seq transfer
	always_comb begin
		req.sel   = hsel & hready & htrans[1];
		req.write = hwrite;
		req.addr  = haddr[17:0];
	end

	// word read mux, unmapped addresses read zero
	function automatic logic [31:0] read_word(input logic [17:0] a,
		input logic [7:0] ra, input logic [7:0] rb);
		logic [31:0] w;
		w = 32'h0000_0000;
		if (a == hwopt_pkg::HWOPT_ADDR_A) begin
			w = {24'h00_0000, ra};
		end else if (a == hwopt_pkg::HWOPT_ADDR_B) begin
			w = {24'h00_0000, rb};
		end
		return w;
	endfunction : read_word

	// read data captured at the address phase, writes dropped
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= hwopt_pkg::HWOPT_RDATA_RST;
		end else if (req.sel && !req.write) begin
			hrdata <= read_word(req.addr, opt_a, opt_b);
		end else if (req.sel) begin
			hrdata <= hwopt_pkg::HWOPT_RDATA_RST;
		end
	end

	// zero wait states, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end
	end

endmodule : hwopt_top
`default_nettype wire

/* tb/hwopt_top_monitor.sv */
// option bank checker: port-level properties of the option registers
// assumes it is bound onto hwopt_top with the same option parameters
`timescale 1ns/1ps
`default_nettype none
module hwopt_top_monitor #(
	parameter logic [7:0] OPT_A   = 8'h13,
	parameter logic [1:0] OPT_B   = 2'h0,
	parameter logic       VARIANT = 1'b1
) (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        stop_req,
	input wire logic        stop_ok,
	input wire logic        stop_illegal,
	input wire logic        pgm_read_req,
	input wire logic        monitor_mode,
	input wire logic        pgm_read_ok,
	input wire logic        mon_detect,
	input wire logic        mon_reset,
	input wire logic [17:0] wd_timeout,
	input wire logic [12:0] stop_recovery
);
	// ************************************************************
	// bus and control level properties
	// ************************************************************
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	wire logic take;
	assign take = hsel && hready && htrans[1];

	a_resp_okay: assert property (hresp == 1'b0)
		else $error("error response seen");
	a_ready_high: assert property (hreadyout)
		else $error("wait state inserted");
	a_read_a: assert property (take && !hwrite && haddr == 32'h7c |=> hrdata == {24'h0, OPT_A})
		else $error("register a read wrong");
	a_read_b: assert property (take && !hwrite && haddr == 32'h80 |=>
		hrdata == {24'h0, OPT_B, VARIANT, 5'h0}) else $error("register b read wrong");
	a_write_ignored: assert property (take && hwrite |=> hrdata == 32'h0)
		else $error("write left read data");
	a_stop_gate: assert property ($past(hresetn) |-> stop_ok == ($past(stop_req) && OPT_A[1])
		&& stop_illegal == ($past(stop_req) && !OPT_A[1])) else $error("stop gating wrong");
	a_pgm_guard: assert property ($past(hresetn) |-> pgm_read_ok ==
		($past(pgm_read_req) && !(OPT_A[6] && $past(monitor_mode)))) else $error("pgm gate wrong");
	a_mon_reset: assert property (mon_reset |-> OPT_A[5] && OPT_A[4] && $past(mon_detect))
		else $error("monitor reset unexpected");
	a_wd_period: assert property ($past(hresetn) |-> wd_timeout == (OPT_A[2] ? 18'h01ff0 : 18'h3fff0))
		else $error("watchdog period wrong");
	a_stop_delay: assert property ($past(hresetn) |-> stop_recovery == (OPT_A[3] ? 13'h0020 : 13'h1000))
		else $error("stop recovery wrong");
endmodule : hwopt_top_monitor

bind hwopt_top hwopt_top_monitor #(.OPT_A(OPT_A), .OPT_B(OPT_B), .VARIANT(VARIANT)) u_mon (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.stop_req, .stop_ok, .stop_illegal, .pgm_read_req, .monitor_mode, .pgm_read_ok,
	.mon_detect, .mon_reset, .wd_timeout, .stop_recovery);
`default_nettype wire

/* tb/hwopt_top_tb.sv */
// option bank testbench: bus reads and gate levels against a model
// assumes hwopt_top and its checker are compiled before this file
`timescale 1ns/1ps
`default_nettype none
module hwopt_top_tb;
	// ************************************************************
	// stimulus, model and comparison
	// ************************************************************
	localparam logic [7:0] A = 8'h75; // short recovery left clear, crystal build
	localparam logic [1:0] B = 2'h3;
	localparam logic       V = 1'b1; // arbitrary variant value
	logic        hclk = 1'b0;
	logic        hresetn = 1'b0;
	logic        hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [6:0]  gi = 7'h0; // stop, pgm, ee, mon mode, code ok, detect, in stop
	logic [31:0] hrdata, rd;
	logic        hreadyout, hresp, wd_en, ee_clk;
	logic [17:0] wd_t;
	logic [12:0] rec_t;
	logic [5:0]  e;
	wire logic   hready;
	wire logic [5:0] go;
	int          error_cnt = 0;
	int          checks_done = 0;
	int          seed = 62;
	int          q[$];
	logic [31:0] ad[7] = '{32'h7c, 32'h80, 32'h84, 32'h7c, 32'h80, 32'h7c, 32'h80};
	logic        wr[7] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};

	assign hready = hreadyout; // single slave drives bus ready
	always #2.5 hclk = ~hclk;

	hwopt_top #(.OPT_A(A), .OPT_B(B), .VARIANT(V)) u_dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hburst(3'h0), .hprot(4'h3), .hmastlock(1'b0),
		.hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.stop_req(gi[6]), .pgm_read_req(gi[5]), .ee_read_req(gi[4]), .monitor_mode(gi[3]),
		.ee_code_ok(gi[2]), .mon_detect(gi[1]), .in_stop(gi[0]), .stop_ok(go[5]),
		.stop_illegal(go[4]), .pgm_read_ok(go[3]), .ee_read_ok(go[2]), .mon_active(go[1]),
		.mon_reset(go[0]), .wd_enable(wd_en), .wd_timeout(wd_t), .stop_recovery(rec_t),
		.ee_clk_bus(ee_clk));

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	task automatic chk_rd(input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value hrdata exp %h got %h", exp, got);
		end
	endtask : chk_rd

	task automatic chk_lvl(input string nm, input logic [17:0] exp, input logic [17:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : chk_lvl

	// bounded wait for the slave to accept a phase
	task automatic wait_rdy;
		int n;
		n = 0;
		@(posedge hclk);
		while (hready !== 1'b1) begin
			if (++n > 20) begin
				error_cnt++;
				wrap_up();
			end
			@(posedge hclk);
		end
	endtask : wait_rdy

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : bus

	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// expected read values from the option bytes and one unmapped word, writes in between
		q = '{{24'h0, A}, {24'h0, B, V, 5'h0}, 32'h0, 32'h0, 32'h0, {24'h0, A}, {24'h0, B, V, 5'h0}};
		for (int i = 0; i < 7; i++) begin
			bus(ad[i], wr[i], 32'hffff_ffff);
			if (!wr[i])
				chk_rd(q[i], rd);
		end
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		bus(32'h7c, 1'b0, 32'h0);
		chk_rd(q[0], rd);
		$display("register test done");
		// random control levels held two edges, then compared
		for (int i = 0; i < 100; i++) begin
			gi <= 7'($random(seed));
			repeat (2) @(posedge hclk);
			#1;
			e[5] = gi[6] & A[1];
			e[4] = gi[6] & ~A[1];
			e[3] = gi[5] & ~(A[6] & gi[3]);
			e[2] = gi[4] & ~(B[0] & gi[3] & ~gi[2]);
			e[1] = A[4] & (~gi[0] | A[7]);
			e[0] = e[1] & A[5] & gi[1];
			chk_lvl("gates", {12'h0, e}, {12'h0, go});
			@(posedge hclk);
		end
		chk_lvl("wd_timeout", A[2] ? 18'h01ff0 : 18'h3fff0, wd_t);
		chk_lvl("stop_recovery", A[3] ? 18'h00020 : 18'h01000, {5'h0, rec_t});
		chk_lvl("wd_enable", {17'h0, ~A[0]}, {17'h0, wd_en});
		chk_lvl("ee_clk_bus", {17'h0, B[1]}, {17'h0, ee_clk});
		$display("gate test done");
		wrap_up();
	end
endmodule : hwopt_top_tb
`default_nettype wire
